// File: hw/zx_pkg.sv
// Constants for the zero-cross detector control block.
// Assumes an 8-bit register port with 12-bit byte addresses.
`default_nettype none
package zx_pkg;
  // ****************
  // Bus widths
  // ****************
  localparam int ZX_AW = 12;
  localparam int ZX_DW = 8;
  // ****************
  // Register offsets
  // ****************
  localparam logic [11:0] ZX_CTRL_OFS = 12'h21F;
  localparam logic [11:0] ZX_STAT_OFS = 12'h220;
  localparam logic [11:0] ZX_MASK_OFS = 12'h221;
  // ****************
  // Control, status and mask fields
  // ****************
  localparam int ZX_SOFT_EN_BIT = 7;
  localparam int ZX_OUT_BIT = 5;
  localparam int ZX_INVERT_BIT = 4;
  localparam int ZX_RISE_BIT = 1;
  localparam int ZX_FALL_BIT = 0;
  localparam int ZX_FLAG_BIT = 0;
  // ****************
  // Reset values
  // ****************
  localparam logic SOFT_EN_RST = 1'h0;
  localparam logic INVERT_RST = 1'h0;
  // Fuse chain starts at the disabled level
  localparam logic FUSE_SYNC_RST = 1'h1;
  localparam logic RISE_RST = 1'h0;
  localparam logic FALL_RST = 1'h0;
  localparam logic OUT_RST = 1'h0;
  localparam logic FLAG_RST = 1'h0;
  localparam logic MASK_RST = 1'h0;
  localparam logic [7:0] ZX_RDATA_RST = 8'h00;
endpackage

`default_nettype wire

// File: hw/zx_ctrl.sv
// Zero-cross detector control: enable, output polarity, edge flag, irq.
// Assumes an analog comparator and stage outside; fuse and disable
// bits arrive as pins and are synchronised here.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
`default_nettype none

module zx_ctrl (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Register port
  input wire logic [zx_pkg::ZX_AW-1:0] i_addr,
  input wire logic [zx_pkg::ZX_DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [zx_pkg::ZX_DW-1:0] o_rdata,
  // Analog side and configuration pins
  input wire logic i_cmp_sink,
  input wire logic i_cfg_fuse,
  input wire logic i_zc_module_disable,
  output logic o_stage_en,
  output logic o_pin_force,
  output logic o_zc_out,
  // Interrupt
  output logic o_irq
);
  import zx_pkg::*;

  // ****************
  // Functions
  // ****************
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  // ****************
  // Declarations
  // ****************
  logic cmp_s1_r, cmp_s2_r;
  logic fuse_s1_r, fuse_s2_r;
  logic md_s1_r, md_s2_r;
  logic soft_en_r, invert_r, rise_en_r, fall_en_r;
  logic out_r, prev_r, en_r;
  logic flag_r, mask_r;
  logic [7:0] rdata_r;
  logic wr_ctrl, wr_stat, wr_mask;
  logic rd_ctrl, rd_stat, rd_mask;
  logic en_nxt, out_nxt, rise_ev, fall_ev, invert_ev, flag_clr, flag_set, flag_nxt;
  logic [7:0] ctrl_view, rdata_nxt;

  // ****************
  // Address decode
  // ****************
  assign wr_ctrl = i_wr & hit(i_addr, ZX_CTRL_OFS);
  assign wr_stat = i_wr & hit(i_addr, ZX_STAT_OFS);
  assign wr_mask = i_wr & hit(i_addr, ZX_MASK_OFS);
  assign rd_ctrl = i_rd & hit(i_addr, ZX_CTRL_OFS);
  assign rd_stat = i_rd & hit(i_addr, ZX_STAT_OFS);
  assign rd_mask = i_rd & hit(i_addr, ZX_MASK_OFS);

  // ****************
  // Input synchronisers
  // ****************
  // two-stage comparator sync
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmp_s1_r <= 1'h0;
      cmp_s2_r <= 1'h0;
      // No forced pin while the fuse is still unknown
      fuse_s1_r <= FUSE_SYNC_RST;
      fuse_s2_r <= FUSE_SYNC_RST;
      md_s1_r <= 1'h0;
      md_s2_r <= 1'h0;
    end else begin
      cmp_s1_r <= i_cmp_sink;
      cmp_s2_r <= cmp_s1_r;
      fuse_s1_r <= i_cfg_fuse;
      fuse_s2_r <= fuse_s1_r;
      md_s1_r <= i_zc_module_disable;
      md_s2_r <= md_s1_r;
    end
  end

  // ****************
  // Enable logic
  // ****************
  // fuse clear forces enable
  assign en_nxt = !fuse_s2_r ? 1'h1 : (soft_en_r & ~md_s2_r);

  // ****************
  // Output and edges
  // ****************
  // sink level gated by enable, xor invert
  assign out_nxt = (en_r & cmp_s2_r) ^ invert_r;
  assign rise_ev = out_r & ~prev_r;
  assign fall_ev = ~out_r & prev_r;
  assign invert_ev = wr_ctrl & (i_wdata[ZX_INVERT_BIT] != invert_r);
  assign flag_clr = wr_stat & i_wdata[ZX_FLAG_BIT];
  assign flag_set = (rise_ev & rise_en_r) | (fall_ev & fall_en_r) | invert_ev;
  assign flag_nxt = flag_set | (flag_r & ~flag_clr);

  // ****************
  // Read mux
  // ****************
  // unimplemented bits read zero
  assign ctrl_view = {soft_en_r, 1'h0, out_r, invert_r, 2'h0, rise_en_r, fall_en_r};
  assign rdata_nxt = rd_ctrl ? ctrl_view :
                     rd_stat ? {7'h00, flag_r} :
                     rd_mask ? {7'h00, mask_r} : ZX_RDATA_RST;

  // ****************
  // Control register
  // ****************
  // control fields and resets
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      soft_en_r <= SOFT_EN_RST;
      invert_r <= INVERT_RST;
      rise_en_r <= RISE_RST;
      fall_en_r <= FALL_RST;
    end else if (wr_ctrl) begin
      soft_en_r <= i_wdata[ZX_SOFT_EN_BIT];
      invert_r <= i_wdata[ZX_INVERT_BIT];
      rise_en_r <= i_wdata[ZX_RISE_BIT];
      fall_en_r <= i_wdata[ZX_FALL_BIT];
    end
  end

  // ****************
  // Detector state
  // ****************
  // no sleep gating here
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en_r <= 1'h0;
      out_r <= OUT_RST;
      prev_r <= OUT_RST;
    end else begin
      en_r <= en_nxt;
      out_r <= out_nxt;
      prev_r <= out_r;
    end
  end

  // ****************
  // Interrupt and read data registers
  // ****************
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag_r <= FLAG_RST;
      mask_r <= MASK_RST;
      rdata_r <= ZX_RDATA_RST;
    end else begin
      flag_r <= flag_nxt;
      if (wr_mask) begin
        mask_r <= i_wdata[ZX_FLAG_BIT];
      end
      rdata_r <= rdata_nxt;
    end
  end

  // ****************
  // Outputs
  // ****************
  assign o_stage_en = en_r;
  assign o_pin_force = en_r;
  assign o_zc_out = out_r;
  assign o_irq = flag_r & mask_r;
  assign o_rdata = rdata_r;

  // ****************
  // Assertions
  // ****************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  a_fuse_always_on: assert property (
    (!fuse_s2_r ##1 1'b1) |-> o_stage_en
  ) else $error("stage off while fuse clear");

  a_soft_enable_follow: assert property (
    (fuse_s2_r && !md_s2_r) |=> (o_stage_en == $past(soft_en_r))
  ) else $error("stage enable does not follow soft enable");

  a_soft_enable_off: assert property (
    (fuse_s2_r && !soft_en_r) |=> !o_stage_en
  ) else $error("stage on with soft enable clear");

  a_module_disable_off: assert property (
    (fuse_s2_r && md_s2_r) |=> !o_stage_en
  ) else $error("module disable ignored");

  a_out_polarity: assert property (
    ##1 (o_zc_out == ($past(en_r & cmp_s2_r) ^ $past(invert_r)))
  ) else $error("output polarity wrong");

  a_idle_out_fixed: assert property (
    !en_r |=> (o_zc_out == $past(invert_r))
  ) else $error("output moved while detector disabled");

  a_rise_sets_flag: assert property (
    (rise_en_r && o_zc_out && !prev_r) |=> flag_r
  ) else $error("rising edge missed");

  a_fall_sets_flag: assert property (
    (fall_en_r && !o_zc_out && prev_r) |=> flag_r
  ) else $error("falling edge missed");

  a_quiet_flag_hold: assert property (
    (!flag_set && !flag_clr) |=> $stable(flag_r)
  ) else $error("flag changed without cause");

  a_rise_ignored: assert property (
    (rise_ev && !rise_en_r && !invert_ev && !flag_clr) |=> $stable(flag_r)
  ) else $error("disabled rising edge set flag");

  a_fall_ignored: assert property (
    (fall_ev && !fall_en_r && !invert_ev && !flag_clr) |=> $stable(flag_r)
  ) else $error("disabled falling edge set flag");

  a_invert_change_flag: assert property (
    (i_wr && i_addr == ZX_CTRL_OFS && i_wdata[ZX_INVERT_BIT] != invert_r) |=> flag_r
  ) else $error("invert change did not set flag");

  a_set_beats_clear: assert property (
    (flag_clr && flag_set) |=> flag_r
  ) else $error("clear beat a new event");

  a_clear_works: assert property (
    (flag_clr && !flag_set) |=> !flag_r
  ) else $error("flag not cleared");

  a_flag_sticky: assert property (
    (flag_r && !flag_clr) |=> flag_r
  ) else $error("flag dropped without clear");

  a_ctrl_read_view: assert property (
    (i_rd && i_addr == ZX_CTRL_OFS) |=>
      (o_rdata[6] == 1'b0 && o_rdata[3:2] == 2'b00 && o_rdata[5] == $past(out_r))
  ) else $error("control read view wrong");

  a_ctrl_bits_view: assert property (
    (i_rd && i_addr == ZX_CTRL_OFS) |=>
      (o_rdata[7] == $past(soft_en_r) && o_rdata[4] == $past(invert_r))
  ) else $error("control enable or invert read wrong");

  a_out_read_only: assert property (
    (i_wr && i_addr == ZX_CTRL_OFS) |=> (o_zc_out == ($past(en_r & cmp_s2_r) ^ $past(invert_r)))
  ) else $error("output bit written");

  a_ctrl_write_fields: assert property (
    (i_wr && i_addr == ZX_CTRL_OFS) |=> (soft_en_r == $past(i_wdata[ZX_SOFT_EN_BIT]) &&
      rise_en_r == $past(i_wdata[ZX_RISE_BIT]) && fall_en_r == $past(i_wdata[ZX_FALL_BIT]))
  ) else $error("control fields not written");

  a_ctrl_hold: assert property (
    !(i_wr && i_addr == ZX_CTRL_OFS) |=> ($stable(soft_en_r) && $stable(invert_r))
  ) else $error("control fields changed without write");

  a_ctrl_reset_zero: assert property (
    $rose(i_rst_n) |-> (!soft_en_r && !invert_r && !rise_en_r && !fall_en_r)
  ) else $error("control fields not reset");

  a_sync_two_stage: assert property (
    ##2 (cmp_s2_r == $past(i_cmp_sink, 2))
  ) else $error("comparator sync depth wrong");

  a_rdata_idle_zero: assert property (
    !i_rd |=> (o_rdata == 8'h00)
  ) else $error("read data outside read slot");

  a_unmapped_read_zero: assert property (
    (i_rd && i_addr != ZX_CTRL_OFS && i_addr != ZX_STAT_OFS && i_addr != ZX_MASK_OFS) |=>
      (o_rdata == 8'h00)
  ) else $error("unmapped read returned data");

  a_stat_read_view: assert property (
    (i_rd && i_addr == ZX_STAT_OFS) |=> (o_rdata == {7'h00, $past(flag_r)})
  ) else $error("status read view wrong");

  a_irq_level: assert property (
    o_irq == (flag_r && mask_r)
  ) else $error("irq does not match flag and mask");

endmodule // zx_ctrl

`default_nettype wire

// File: tb/zx_ac_src.sv
// AC source model: drives the comparator sink level.
// Assumes the bench commands the wanted level and a slow mode.
`timescale 1ns/100ps
`default_nettype none
module zx_ac_src (
  // Clock and command
  input wire logic i_sys_clk,
  input wire logic i_level,
  input wire logic i_slow,
  // Comparator
  output logic o_cmp_sink
);
  logic [1:0] dly_r = 2'h0;
  logic cmp_r = 1'h0;
  always @(posedge i_sys_clk) begin
    dly_r <= {dly_r[0], i_level};
    cmp_r <= i_slow ? dly_r[1] : i_level;
  end
  assign o_cmp_sink = cmp_r;
endmodule // zx_ac_src
`default_nettype wire

// File: tb/tb_top.sv
// Testbench for the zero-cross control block.
// Assumes the AC source model drives the comparator input.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import zx_pkg::*;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [11:0] addr = 12'h000;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic fuse = 1'h1;
  logic mdis = 1'h0;
  logic lvl = 1'h0;
  logic slow = 1'h0;
  logic cmp, stage_en, pin_force, zc_out, irq;
  int errors = 0;
  int tests_run = 0;
  always #25 clk = ~clk;
  zx_ac_src i_src (.i_sys_clk(clk), .i_level(lvl), .i_slow(slow), .o_cmp_sink(cmp));
  zx_ctrl i_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_cmp_sink(cmp), .i_cfg_fuse(fuse),
    .i_zc_module_disable(mdis), .o_stage_en(stage_en), .o_pin_force(pin_force),
    .o_zc_out(zc_out), .o_irq(irq));
  // ****************
  // Tasks
  // ****************
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task automatic rd_reg(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    #1 chk("rdata", rdata, e);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ****************
  // Sequence
  // ****************
  initial begin
    step(6);
    rst_n <= 1'h1;
    rd_reg(ZX_CTRL_OFS, 8'h00);
    rd_reg(12'h300, 8'h00);
    $display("test reset done");
    wr_reg(ZX_MASK_OFS, 8'h01);
    rd_reg(ZX_MASK_OFS, 8'h01);
    wr_reg(ZX_CTRL_OFS, 8'hEF);
    rd_reg(ZX_CTRL_OFS, 8'h83);
    chk("stage", {6'h00, stage_en, pin_force}, 8'h03);
    lvl <= 1'h1;
    step(8);
    chk("zc_out", {7'h00, zc_out}, 8'h01);
    rd_reg(ZX_STAT_OFS, 8'h01);
    chk("irq", {7'h00, irq}, 8'h01);
    wr_reg(ZX_STAT_OFS, 8'h01);
    rd_reg(ZX_STAT_OFS, 8'h00);
    chk("irq", {7'h00, irq}, 8'h00);
    slow <= 1'h1;
    lvl <= 1'h0;
    step(10);
    rd_reg(ZX_STAT_OFS, 8'h01);
    wr_reg(ZX_STAT_OFS, 8'h01);
    slow <= 1'h0;
    lvl <= 1'h1;
    step(3);
    wr_reg(ZX_STAT_OFS, 8'h01);
    rd_reg(ZX_STAT_OFS, 8'h01);
    slow <= 1'h1;
    lvl <= 1'h0;
    step(8);
    wr_reg(ZX_STAT_OFS, 8'h01);
    wr_reg(ZX_CTRL_OFS, 8'h81);
    lvl <= 1'h1;
    step(10);
    rd_reg(ZX_STAT_OFS, 8'h00);
    rd_reg(ZX_CTRL_OFS, 8'hA1);
    $display("test edges done");
    wr_reg(ZX_CTRL_OFS, 8'h90);
    step(4);
    rd_reg(ZX_STAT_OFS, 8'h01);
    rd_reg(ZX_CTRL_OFS, 8'h90);
    wr_reg(ZX_MASK_OFS, 8'h00);
    step(1);
    chk("irq", {7'h00, irq}, 8'h00);
    $display("test polarity done");
    mdis <= 1'h1;
    step(5);
    chk("stage", {6'h00, stage_en, pin_force}, 8'h00);
    fuse <= 1'h0;
    wr_reg(ZX_CTRL_OFS, 8'h00);
    step(5);
    chk("stage", {6'h00, stage_en, pin_force}, 8'h03);
    fuse <= 1'h1;
    mdis <= 1'h0;
    step(5);
    chk("stage", {6'h00, stage_en, pin_force}, 8'h00);
    $display("test enable done");
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
